// File: core/sdcd_params.svh
`ifndef SDCD_PARAMS_SVH
`define SDCD_PARAMS_SVH
// ************************************************************
// bank geometry and latency defaults
// ************************************************************
`define SDCD_NUM_BANKS 4
`define SDCD_BANK_W 2
`define SDCD_CAS_LAT_DEF 3
`define SDCD_BURST_LEN_DEF 8
`define SDCD_CNT_W 9
`define SDCD_FULL_PAGE_LEN 256
`endif

// File: core/sdcd_pkg.sv
package sdcd_pkg;
  // host-side command requests
  typedef enum logic [3:0] {
    SDCD_REQ_NOP = 4'h0,
    SDCD_REQ_ACT = 4'h1,
    SDCD_REQ_PRE = 4'h2,
    SDCD_REQ_RD = 4'h3,
    SDCD_REQ_WR = 4'h4,
    SDCD_REQ_MRS = 4'h5,
    SDCD_REQ_STOP = 4'h6,
    SDCD_REQ_AREF = 4'h7,
    SDCD_REQ_SREF = 4'h8,
    SDCD_REQ_PDN = 4'h9,
    SDCD_REQ_WAKE = 4'hA,
    SDCD_REQ_DESEL = 4'hB,
    SDCD_REQ_SUSP = 4'hC
  } sdcd_req_t;
  // device power state, one-hot
  typedef enum logic [3:0] {
    SDCD_ST_NORMAL = 4'b0001,
    SDCD_ST_PDOWN = 4'b0010,
    SDCD_ST_SUSP = 4'b0100,
    SDCD_ST_SREF = 4'b1000
  } sdcd_state_t;
endpackage

// File: core/sdcd_if.sv
`timescale 1ns/10ps
interface sdcd_if;
  logic chip_sel_n;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_en_n;
  logic bank_select_low;
  logic bank_select_high;
  logic precharge_qualifier_bit;
  logic byte_mask;
  logic clock_enable_current;
  modport ctrl (
    output chip_sel_n, row_strobe_n, col_strobe_n, write_en_n,
    output bank_select_low, bank_select_high, precharge_qualifier_bit,
    output byte_mask, clock_enable_current
  );
  modport dev (
    input chip_sel_n, row_strobe_n, col_strobe_n, write_en_n,
    input bank_select_low, bank_select_high, precharge_qualifier_bit,
    input byte_mask, clock_enable_current
  );
endinterface

// File: core/sdcd_device.sv
// Behaviour
// - sample command pins on rising clock only
// - decode uses previous and current clock enable
// - bank commands act on selected bank
// - burst stop is LHHL, full-page only
// - no power down during a burst
// - enable fall in burst means suspend
// - active bank plus enable fall: suspend
// - enable rise leaves suspend, ignores rest
// - enable fall with nop/deselect: power down
// - enable rise with nop/deselect: wake up
// - idle LLLH with enable falling: self refresh
// - pin patterns decode to command set
// - qualifier bit selects all-bank or auto-precharge
// - byte mask gates write data and outputs
// - controller gives write data from command cycle
// - read stop releases outputs after latency
`timescale 1ns/10ps
`include "sdcd_params.svh"
module sdcd_device
  import sdcd_pkg::*;
#(
  parameter int CAS_LAT = `SDCD_CAS_LAT_DEF,
  parameter int BURST_LEN = `SDCD_BURST_LEN_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command pins
  sdcd_if.dev pins,
  // decoded command pulses
  output logic cmd_act_ff,
  output logic cmd_pre_ff,
  output logic cmd_pre_all_ff,
  output logic cmd_rd_ff,
  output logic cmd_wr_ff,
  output logic cmd_auto_pre_ff,
  output logic cmd_mrs_ff,
  output logic cmd_stop_ff,
  output logic cmd_aref_ff,
  output logic [`SDCD_BANK_W-1:0] cmd_bank_ff,
  // status
  output logic [`SDCD_NUM_BANKS-1:0] bank_active_ff,
  output logic [3:0] pwr_state_ff,
  output logic burst_busy_ff,
  output logic write_data_en_ff,
  output logic out_drive_en_ff
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [8:0] sync1_ff;
  logic [8:0] sync2_ff;
  logic clock_enable_previous;
  // two stages because pins come from outside logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_ff <= 9'h1FF;
      sync2_ff <= 9'h1FF;
    end else begin
      sync1_ff <= {pins.chip_sel_n, pins.row_strobe_n, pins.col_strobe_n,
                   pins.write_en_n, pins.bank_select_high, pins.bank_select_low,
                   pins.precharge_qualifier_bit, pins.byte_mask,
                   pins.clock_enable_current};
      sync2_ff <= sync1_ff;
    end
  end
  // previous enable level kept from the last edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_enable_previous <= 1'b1;
    end else begin
      clock_enable_previous <= sync2_ff[0];
    end
  end
  // ************************************************************
  // pattern decode
  // ************************************************************
  wire cs_n = sync2_ff[8];
  wire ras_n = sync2_ff[7];
  wire cas_n = sync2_ff[6];
  wire we_n = sync2_ff[5];
  wire [`SDCD_BANK_W-1:0] bank_sel = sync2_ff[4:3];
  wire qual = sync2_ff[2];
  wire mask = sync2_ff[1];
  wire cke_cur = sync2_ff[0];
  wire [3:0] pat = {cs_n, ras_n, cas_n, we_n};
  sdcd_state_t state_ff;
  sdcd_state_t nxt_state;
  wire normal = (state_ff == SDCD_ST_NORMAL);
  wire hh = normal && clock_enable_previous && cke_cur;
  wire hl = clock_enable_previous && !cke_cur;
  wire lh = !clock_enable_previous && cke_cur;
  wire any_active = |bank_active_ff;
  // deselect masks everything else because cs_n leads the pattern
  wire is_act = hh && (pat == 4'h3);
  wire is_pre = hh && (pat == 4'h2);
  wire is_wr = hh && (pat == 4'h4);
  wire is_rd = hh && (pat == 4'h5);
  wire is_mrs = hh && (pat == 4'h0);
  wire is_stop = hh && (pat == 4'h6) && burst_busy_ff && (BURST_LEN == 0);
  wire is_aref = hh && (pat == 4'h1) && !any_active;
  wire nop_or_desel = cs_n || (ras_n && cas_n);
  wire go_sref = normal && hl && (pat == 4'h1) && !any_active;
  wire go_susp = normal && hl && (burst_busy_ff || any_active) && !go_sref;
  wire go_pdn = normal && hl && nop_or_desel && !burst_busy_ff && !any_active;
  // bank hit decode per selected bank
  wire [`SDCD_NUM_BANKS-1:0] bank_hit = `SDCD_NUM_BANKS'(1) << bank_sel;
  // ************************************************************
  // power state machine
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SDCD_ST_NORMAL: begin
        if (go_sref) begin
          nxt_state = SDCD_ST_SREF;
        end else if (go_susp) begin
          nxt_state = SDCD_ST_SUSP;
        end else if (go_pdn) begin
          nxt_state = SDCD_ST_PDOWN;
        end
      end
      SDCD_ST_SUSP: begin
        if (lh) begin
          nxt_state = SDCD_ST_NORMAL;
        end
      end
      SDCD_ST_PDOWN: begin
        if (lh && nop_or_desel) begin
          nxt_state = SDCD_ST_NORMAL;
        end
      end
      SDCD_ST_SREF: begin
        if (lh && nop_or_desel) begin
          nxt_state = SDCD_ST_NORMAL;
        end
      end
      default: nxt_state = SDCD_ST_NORMAL;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= SDCD_ST_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // ************************************************************
  // bank and burst tracking
  // ************************************************************
  logic [`SDCD_CNT_W-1:0] burst_cnt_ff;
  logic [`SDCD_CNT_W-1:0] hz_cnt_ff;
  logic rd_burst_ff;
  wire [`SDCD_CNT_W-1:0] blen = (BURST_LEN == 0) ?
    `SDCD_CNT_W'(`SDCD_FULL_PAGE_LEN) : `SDCD_CNT_W'(BURST_LEN);
  wire start = (is_rd || is_wr) && bank_active_ff[bank_sel];
  wire pre_all = is_pre && qual;
  wire [`SDCD_NUM_BANKS-1:0] clr_mask = pre_all ? {`SDCD_NUM_BANKS{1'b1}} :
    (is_pre ? bank_hit : '0);
  wire [`SDCD_NUM_BANKS-1:0] set_mask = is_act ? bank_hit : '0;
  // bank open flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_active_ff <= '0;
    end else begin
      bank_active_ff <= (bank_active_ff & ~clr_mask) | set_mask;
    end
  end
  // burst counter runs only in the normal state; full page holds its count until stopped
  wire last_beat = (burst_cnt_ff == `SDCD_CNT_W'(1)) && (BURST_LEN != 0);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      burst_cnt_ff <= '0;
      burst_busy_ff <= 1'b0;
      rd_burst_ff <= 1'b0;
    end else if (start) begin
      burst_cnt_ff <= blen;
      burst_busy_ff <= 1'b1;
      rd_burst_ff <= is_rd;
    end else if (is_stop || (burst_busy_ff && normal && last_beat)) begin
      burst_cnt_ff <= '0;
      burst_busy_ff <= 1'b0;
    end else if (burst_busy_ff && normal && (BURST_LEN != 0)) begin
      burst_cnt_ff <= burst_cnt_ff - `SDCD_CNT_W'(1);
    end
  end
  // outputs float latency cycles after a read stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hz_cnt_ff <= '0;
    end else if (is_stop && rd_burst_ff) begin
      hz_cnt_ff <= `SDCD_CNT_W'(CAS_LAT);
    end else if (hz_cnt_ff != '0) begin
      hz_cnt_ff <= hz_cnt_ff - `SDCD_CNT_W'(1);
    end
  end
  wire drive_ok = rd_burst_ff && (burst_busy_ff || (hz_cnt_ff > `SDCD_CNT_W'(1)));
  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_act_ff <= 1'b0;
      cmd_pre_ff <= 1'b0;
      cmd_pre_all_ff <= 1'b0;
      cmd_rd_ff <= 1'b0;
      cmd_wr_ff <= 1'b0;
      cmd_auto_pre_ff <= 1'b0;
      cmd_mrs_ff <= 1'b0;
      cmd_stop_ff <= 1'b0;
      cmd_aref_ff <= 1'b0;
      cmd_bank_ff <= '0;
      pwr_state_ff <= 4'h1;
      write_data_en_ff <= 1'b0;
      out_drive_en_ff <= 1'b0;
    end else begin
      cmd_act_ff <= is_act;
      cmd_pre_ff <= is_pre && !qual;
      cmd_pre_all_ff <= pre_all;
      cmd_rd_ff <= is_rd;
      cmd_wr_ff <= is_wr;
      cmd_auto_pre_ff <= (is_rd || is_wr) && qual;
      cmd_mrs_ff <= is_mrs && !any_active;
      cmd_stop_ff <= is_stop;
      cmd_aref_ff <= is_aref;
      cmd_bank_ff <= bank_sel;
      pwr_state_ff <= nxt_state;
      // mask high blocks write data and output drive
      write_data_en_ff <= normal && cke_cur && any_active && !mask && !rd_burst_ff;
      out_drive_en_ff <= normal && cke_cur && !mask && drive_ok;
    end
  end
endmodule

// File: core/sdcd_ctrl.sv
`timescale 1ns/10ps
`include "sdcd_params.svh"
module sdcd_ctrl
  import sdcd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  input wire sdcd_req_t req_cmd,
  input wire logic [`SDCD_BANK_W-1:0] req_bank,
  input wire logic req_qual,
  input wire logic req_mask,
  output logic req_taken_ff,
  // pins toward device
  sdcd_if.ctrl pins
);
  // ************************************************************
  // pin pattern encode
  // ************************************************************
  logic [3:0] pat_ff;
  logic cke_ff;
  logic [`SDCD_BANK_W-1:0] bank_ff;
  logic qual_ff;
  logic mask_ff;
  wire sdcd_req_t cmd = req_valid ? req_cmd : SDCD_REQ_NOP;
  // pattern is cs ras cas we, all active low
  wire [3:0] nxt_pat =
    (cmd == SDCD_REQ_ACT) ? 4'h3 :
    (cmd == SDCD_REQ_PRE) ? 4'h2 :
    (cmd == SDCD_REQ_RD) ? 4'h5 :
    (cmd == SDCD_REQ_WR) ? 4'h4 :
    (cmd == SDCD_REQ_MRS) ? 4'h0 :
    (cmd == SDCD_REQ_STOP) ? 4'h6 :
    (cmd == SDCD_REQ_AREF) ? 4'h1 :
    (cmd == SDCD_REQ_SREF) ? 4'h1 :
    (cmd == SDCD_REQ_DESEL) ? 4'h8 : 4'h7;
  // enable drops for sleep requests, rises on wake; held otherwise
  wire nxt_cke =
    ((cmd == SDCD_REQ_SREF) || (cmd == SDCD_REQ_PDN) || (cmd == SDCD_REQ_SUSP)) ? 1'b0 :
    (cmd == SDCD_REQ_WAKE) ? 1'b1 : cke_ff;
  // every pin changes on the edge so it is stable at the next one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pat_ff <= 4'h7;
      cke_ff <= 1'b1;
      bank_ff <= '0;
      qual_ff <= 1'b0;
      mask_ff <= 1'b1;
      req_taken_ff <= 1'b0;
    end else begin
      pat_ff <= nxt_pat;
      cke_ff <= nxt_cke;
      bank_ff <= req_bank;
      qual_ff <= req_qual;
      mask_ff <= req_mask; // leaves with the command
      req_taken_ff <= req_valid;
    end
  end
  assign pins.chip_sel_n = pat_ff[3];
  assign pins.row_strobe_n = pat_ff[2];
  assign pins.col_strobe_n = pat_ff[1];
  assign pins.write_en_n = pat_ff[0];
  assign pins.bank_select_low = bank_ff[0];
  assign pins.bank_select_high = bank_ff[1];
  assign pins.precharge_qualifier_bit = qual_ff;
  assign pins.byte_mask = mask_ff;
  assign pins.clock_enable_current = cke_ff;
endmodule

// File: testbench/sdcd_checker_assertions.sv
`timescale 1ns/10ps
`include "sdcd_params.svh"
module sdcd_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command pins
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic precharge_qualifier_bit,
  input wire logic byte_mask,
  input wire logic clock_enable_current,
  // decoded outputs
  input wire logic cmd_act_ff,
  input wire logic cmd_pre_ff,
  input wire logic cmd_pre_all_ff,
  input wire logic cmd_rd_ff,
  input wire logic cmd_wr_ff,
  input wire logic cmd_auto_pre_ff,
  input wire logic cmd_mrs_ff,
  input wire logic [`SDCD_BANK_W-1:0] cmd_bank_ff,
  input wire logic [`SDCD_NUM_BANKS-1:0] bank_active_ff,
  input wire logic [3:0] pwr_state_ff,
  input wire logic burst_busy_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ************************************************************
  // pin decode helpers
  // ************************************************************
  logic cke_prev_ff;
  wire [3:0] pat = {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n};
  wire [1:0] bank_pins = {bank_select_high, bank_select_low};
  wire live = cke_prev_ff && clock_enable_current && (pwr_state_ff == 4'h1);
  wire any_cmd = cmd_act_ff || cmd_pre_ff || cmd_pre_all_ff || cmd_rd_ff || cmd_wr_ff;
  // previous enable level, kept here so the decode guard is one wire
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cke_prev_ff <= 1'b1;
    end else begin
      cke_prev_ff <= clock_enable_current;
    end
  end
  sequence s_act_seen;
    live && (pat == 4'h3);
  endsequence
  sequence s_desel_seen;
    live && chip_sel_n;
  endsequence
  // ************************************************************
  // decode timing: 3 sampled edges from pins to pulse
  // ************************************************************
  act_decode_a: assert property (
      s_act_seen |-> ##3 (cmd_act_ff && cmd_bank_ff == $past(bank_pins, 3)))
    else $error("activate not decoded on named bank");
  rd_decode_a: assert property (cmd_rd_ff |-> $past(pat, 3) == 4'h5)
    else $error("read pulse without read pattern");
  wr_decode_a: assert property (cmd_wr_ff |-> $past(pat, 3) == 4'h4)
    else $error("write pulse without write pattern");
  auto_pre_a: assert property (
      cmd_auto_pre_ff |-> $past(precharge_qualifier_bit, 3) && (cmd_rd_ff || cmd_wr_ff))
    else $error("auto precharge without qualifier");
  pre_kind_a: assert property (
      (cmd_pre_ff || cmd_pre_all_ff) |-> ($past(pat, 3) == 4'h2) &&
      (cmd_pre_all_ff == $past(precharge_qualifier_bit, 3)))
    else $error("precharge scope wrong");
  mrs_idle_a: assert property (
      cmd_mrs_ff |-> $past(pat, 3) == 4'h0 && bank_active_ff == 4'h0)
    else $error("mode set wrongly decoded");
  desel_quiet_a: assert property (s_desel_seen |-> ##3 !any_cmd)
    else $error("deselect produced a command");
  pdn_idle_a: assert property (
      $rose(pwr_state_ff[1]) |-> bank_active_ff == 4'h0 && !burst_busy_ff)
    else $error("power down entered while busy");
  reset_nop_a: assert property (
      $fell(rst) |-> pat == 4'h7 && clock_enable_current && byte_mask)
    else $error("pins not idle after reset");
endmodule

// File: testbench/sdram_command_decoder_test.sv
`timescale 1ns/10ps
`include "sdcd_params.svh"
module sdram_command_decoder_test import sdcd_pkg::*; ;
  logic clk_sys, rst, req_valid, req_qual, req_mask, req_taken_ff;
  sdcd_req_t req_cmd;
  logic [1:0] req_bank, cmd_bank_ff;
  logic cmd_act_ff, cmd_pre_ff, cmd_pre_all_ff, cmd_rd_ff, cmd_wr_ff;
  logic cmd_auto_pre_ff, cmd_mrs_ff, cmd_stop_ff, cmd_aref_ff, burst_busy_ff;
  logic [3:0] bank_active_ff, pwr_state_ff;
  logic write_data_en_ff, out_drive_en_ff;
  int fail_count = 0;
  int samples_checked = 0;
  wire [8:0] pulses = {cmd_act_ff, cmd_pre_ff, cmd_pre_all_ff, cmd_rd_ff, cmd_wr_ff,
    cmd_auto_pre_ff, cmd_mrs_ff, cmd_stop_ff, cmd_aref_ff};
  // ************************************************************
  // both ends joined across the pin interface
  // ************************************************************
  sdcd_if bus();
  sdcd_ctrl i_sdcd_ctrl (.clk_sys, .rst, .req_valid, .req_cmd, .req_bank, .req_qual,
    .req_mask, .req_taken_ff, .pins(bus));
  // full-page bursts, the only length at which burst stop is legal
  sdcd_device #(.BURST_LEN(0)) i_sdcd_device (.clk_sys, .rst, .pins(bus), .cmd_act_ff,
    .cmd_pre_ff, .cmd_pre_all_ff, .cmd_rd_ff, .cmd_wr_ff, .cmd_auto_pre_ff, .cmd_mrs_ff,
    .cmd_stop_ff, .cmd_aref_ff, .cmd_bank_ff, .bank_active_ff, .pwr_state_ff, .burst_busy_ff,
    .write_data_en_ff, .out_drive_en_ff);
  sdcd_checker i_sdcd_checker (.clk_sys, .rst, .chip_sel_n(bus.chip_sel_n),
    .row_strobe_n(bus.row_strobe_n), .col_strobe_n(bus.col_strobe_n),
    .write_en_n(bus.write_en_n), .bank_select_low(bus.bank_select_low),
    .bank_select_high(bus.bank_select_high),
    .precharge_qualifier_bit(bus.precharge_qualifier_bit), .byte_mask(bus.byte_mask),
    .clock_enable_current(bus.clock_enable_current), .cmd_act_ff, .cmd_pre_ff,
    .cmd_pre_all_ff, .cmd_rd_ff, .cmd_wr_ff, .cmd_auto_pre_ff, .cmd_mrs_ff, .cmd_bank_ff,
    .bank_active_ff, .pwr_state_ff, .burst_busy_ff);
  // free running 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one request for one cycle, launched and dropped on falling edges
  task send(input sdcd_req_t cmd, input logic [1:0] bank, input logic qual);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_cmd = cmd;
    req_bank = bank;
    req_qual = qual;
    @(negedge clk_sys);
    req_valid = 1'b0;
    check({15'h0, req_taken_ff}, 16'h1);
  endtask
  // window of 8 cycles covers the 4 cycle decode path and keeps requests apart
  task cmd_expect(input sdcd_req_t cmd, input logic [1:0] bank, input logic qual,
    input logic [8:0] exp);
    logic [8:0] seen;
    seen = 9'h000;
    send(cmd, bank, qual);
    repeat (8) begin
      @(negedge clk_sys);
      seen = seen | pulses;
      if (cmd_act_ff === 1'b1) check({14'h0, cmd_bank_ff}, {14'h0, bank});
    end
    check({7'h00, seen}, {7'h00, exp});
  endtask
  task state_expect(input sdcd_req_t cmd, input logic [3:0] exp);
    send(cmd, 2'h0, 1'b0);
    repeat (8) @(negedge clk_sys);
    check({12'h000, pwr_state_ff}, {12'h000, exp});
  endtask
  // watchdog: a hang counts as a failure
  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = SDCD_REQ_NOP;
    req_bank = 2'h0;
    req_qual = 1'b0;
    req_mask = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    cmd_expect(SDCD_REQ_MRS, 2'h0, 1'b0, 9'h004);
    cmd_expect(SDCD_REQ_AREF, 2'h0, 1'b0, 9'h001);
    cmd_expect(SDCD_REQ_DESEL, 2'h3, 1'b1, 9'h000);
    state_expect(SDCD_REQ_PDN, 4'h2);
    cmd_expect(SDCD_REQ_ACT, 2'h2, 1'b0, 9'h000);
    state_expect(SDCD_REQ_WAKE, 4'h1);
    state_expect(SDCD_REQ_SREF, 4'h8);
    state_expect(SDCD_REQ_WAKE, 4'h1);
    cmd_expect(SDCD_REQ_ACT, 2'h2, 1'b0, 9'h100);
    check({12'h000, bank_active_ff}, 16'h0004);
    cmd_expect(SDCD_REQ_ACT, 2'h1, 1'b0, 9'h100);
    cmd_expect(SDCD_REQ_MRS, 2'h0, 1'b0, 9'h000);
    // mask low from here so data enables can be seen
    req_mask = 1'b0;
    cmd_expect(SDCD_REQ_RD, 2'h2, 1'b1, 9'h028);
    check({15'h0, out_drive_en_ff}, 16'h1);
    cmd_expect(SDCD_REQ_STOP, 2'h2, 1'b0, 9'h002);
    check({15'h0, out_drive_en_ff}, 16'h0);
    cmd_expect(SDCD_REQ_WR, 2'h1, 1'b0, 9'h010);
    check({15'h0, write_data_en_ff}, 16'h1);
    state_expect(SDCD_REQ_PDN, 4'h4);
    state_expect(SDCD_REQ_WAKE, 4'h1);
    cmd_expect(SDCD_REQ_STOP, 2'h1, 1'b0, 9'h002);
    state_expect(SDCD_REQ_SUSP, 4'h4);
    state_expect(SDCD_REQ_WAKE, 4'h1);
    cmd_expect(SDCD_REQ_PRE, 2'h1, 1'b0, 9'h080);
    cmd_expect(SDCD_REQ_PRE, 2'h0, 1'b1, 9'h040);
    check({12'h000, bank_active_ff}, 16'h0000);
    finish_test;
  end
endmodule
